// ===== cbse_branch_unit.sv
// cbse_branch_unit: flag condition evaluation and relative target
`timescale 1ns/1ps
`default_nettype none
module cbse_branch_unit #(
  parameter int unsigned PC_W = 12 // program counter width
)(
  input  wire logic [4:0]            op_i,     // operation code
  input  wire cbse_pkg::cbse_sreg_t  flags_i,  // current flags
  input  wire logic [PC_W-1:0]       pc_i,     // current counter
  input  wire logic [6:0]            disp_i,   // signed displacement
  output logic                       taken_o,  // condition true
  output logic [PC_W-1:0]            target_o  // counter plus disp plus one
);

  // ****************************************
  // condition select
  // ****************************************
  always_comb
  begin
    case (op_i)
      cbse_pkg::OP_BRANCH_ON_CARRY_SET:    taken_o = flags_i.c;  // RL1
      cbse_pkg::OP_BRANCH_LOWER_UNSIGNED:  taken_o = flags_i.c;  // RL1
      cbse_pkg::OP_BRANCH_ON_CARRY_CLEAR:  taken_o = ~flags_i.c; // RL1
      cbse_pkg::OP_BRANCH_SAME_OR_HIGHER:  taken_o = ~flags_i.c; // RL1
      cbse_pkg::OP_BRANCH_ON_NEGATIVE:     taken_o = flags_i.n;  // RL2
      cbse_pkg::OP_BRANCH_ON_POSITIVE:     taken_o = ~flags_i.n; // RL2
      cbse_pkg::OP_BRANCH_SIGNED_GE:       taken_o = ~(flags_i.n ^ flags_i.v); // RL3
      cbse_pkg::OP_BRANCH_SIGNED_LT:       taken_o = flags_i.n ^ flags_i.v;    // RL13
      cbse_pkg::OP_BRANCH_HALFCARRY_SET:   taken_o = flags_i.h;  // RL4
      cbse_pkg::OP_BRANCH_HALFCARRY_CLEAR: taken_o = ~flags_i.h; // RL4
      cbse_pkg::OP_BRANCH_TBIT_SET:        taken_o = flags_i.t;  // RL5
      cbse_pkg::OP_BRANCH_TBIT_CLEAR:      taken_o = ~flags_i.t; // RL5
      cbse_pkg::OP_BRANCH_OVERFLOW_SET:    taken_o = flags_i.v;  // RL6
      cbse_pkg::OP_BRANCH_OVERFLOW_CLEAR:  taken_o = ~flags_i.v; // RL6
      cbse_pkg::OP_BRANCH_IRQ_ENABLED:     taken_o = flags_i.i;  // RL7
      cbse_pkg::OP_BRANCH_IRQ_DISABLED:    taken_o = ~flags_i.i; // RL7
      default:                             taken_o = 1'b0;       // not a branch
    endcase
  end

  // ****************************************
  // target: sign-extended displacement plus one
  // ****************************************
  assign target_o = pc_i + {{(PC_W-7){disp_i[6]}}, disp_i} + PC_W'(1); // RL15

endmodule : cbse_branch_unit
`default_nettype wire

// ===== cbse_exec_checker.sv
// cbse_exec_checker: port assertions for the executor
`timescale 1ns/1ps
`default_nettype none
module cbse_exec_checker #(
  parameter int unsigned PC_W = 12 // counter width
)(
  input wire logic            clk_i,    // clock
  input wire logic            rst_i,    // reset
  input wire logic            wb_we_i,  // write
  input wire logic [7:0]      wb_adr_i, // address
  input wire logic [31:0]     wb_dat_i, // write data
  input wire logic            wb_ack_o, // ack
  input wire logic            busy_o,   // executing
  input wire logic [PC_W-1:0] pc_o,     // counter
  input wire logic [7:0]      sreg_o    // flags
);
  logic [4:0]      op_r;  // accepted op
  logic [6:0]      dsp_r; // accepted displacement
  logic [PC_W-1:0] dsx;   // displacement, sign extended
  assign dsx = {{(PC_W-7){dsp_r[6]}}, dsp_r};
  // capture each command at its ack edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      op_r <= 5'h1f;
      dsp_r <= 7'h00;
    end
    else if (wb_ack_o && wb_we_i && wb_adr_i == cbse_pkg::ADR_CMD && !busy_o)
    begin
      op_r <= wb_dat_i[4:0];
      dsp_r <= wb_dat_i[14:8];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_br; $rose(busy_o) && op_r < 5'h10; endsequence
  property p_br_taken; s_br ##1 busy_o |=> !busy_o && pc_o == $past(pc_o, 2) + dsx + 1'b1; endproperty
  a_br_taken: assert property (p_br_taken) else $error("taken target wrong");
  property p_br_skip; s_br ##1 !busy_o |-> pc_o == $past(pc_o) + 1'b1; endproperty
  a_br_skip: assert property (p_br_skip) else $error("untaken counter wrong");
  property p_br_len; s_br |=> ##1 !busy_o; endproperty
  a_br_len: assert property (p_br_len) else $error("branch too long");
  property p_io_len; $rose(busy_o) && op_r inside {5'h10, 5'h11} |=> busy_o ##1 !busy_o; endproperty
  a_io_len: assert property (p_io_len) else $error("io op not two cycles");
  property p_sh_len; $rose(busy_o) && op_r > 5'h11 |=> !busy_o; endproperty
  a_sh_len: assert property (p_sh_len) else $error("shift not one cycle");
  property p_keep; busy_o && op_r < 5'h12 |=> $stable(sreg_o); endproperty
  a_keep: assert property (p_keep) else $error("flags changed");
  property p_sh_v; $fell(busy_o) && op_r > 5'h11 |-> sreg_o[3] == (sreg_o[2] ^ sreg_o[0]); endproperty
  a_sh_v: assert property (p_sh_v) else $error("shift overflow wrong");
  property p_start; $rose(busy_o) |-> $past(wb_ack_o && wb_we_i && wb_adr_i == cbse_pkg::ADR_CMD); endproperty
  a_start: assert property (p_start) else $error("busy without command");
endmodule : cbse_exec_checker
bind cbse_exec_top cbse_exec_checker #(.PC_W(PC_W)) i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .busy_o(busy_o), .pc_o(pc_o), .sreg_o(sreg_o));
`default_nettype wire

// ===== cbse_exec_top.sv
// cbse_exec_top: wishbone-controlled executor for branches, i/o bit ops and shifts
//
// Functional notes
// RL1: carry branches jump to counter plus k plus one
// RL2: negative-flag branches jump on n set/clear
// RL3: signed ge branch when n xor v zero
// RL4: half-carry branches jump on h set/clear
// RL5: t-flag branches jump on t set/clear
// RL6: overflow branches jump on v set/clear
// RL7: interrupt-state branches jump on i set/clear
// RL8: branches take one/two cycles, flags untouched
// RL9: i/o bit set, two cycles, flags untouched
// RL10: i/o bit clear, two cycles, flags untouched
// RL11: left shift inserts zero, one cycle, zcnv
// RL12: right shift inserts zero, one cycle, zcnv
// RL13: signed lt branch when n xor v one
// RL14: shifted-out bit goes into carry
// RL15: displacement is signed two's complement
`timescale 1ns/1ps
`default_nettype none
module cbse_exec_top #(
  parameter int unsigned PC_W     = 12, // program counter width
  parameter int unsigned IO_DEPTH = 32  // number of i/o registers
)(
  input  wire logic            clk_i,     // core clock
  input  wire logic            rst_i,     // sync reset, active high
  input  wire logic            ce_i,      // clock enable
  input  wire logic            wb_cyc_i,  // bus cycle
  input  wire logic            wb_stb_i,  // bus strobe
  input  wire logic            wb_we_i,   // write enable
  input  wire logic [7:0]      wb_adr_i,  // byte address
  input  wire logic [3:0]      wb_sel_i,  // byte lanes
  input  wire logic [31:0]     wb_dat_i,  // write data
  output logic [31:0]          wb_dat_o,  // read data
  output logic                 wb_ack_o,  // acknowledge
  output logic                 busy_o,    // instruction in flight
  output logic [PC_W-1:0]      pc_o,      // program counter
  output logic [7:0]           sreg_o     // status flags
);

  // ****************************************
  // elaboration checks
  // ****************************************
  localparam int unsigned IO_AW = (IO_DEPTH > 1) ? $clog2(IO_DEPTH) : 1; // i/o index width

  generate
    if (PC_W < 8 || PC_W > 16)
    begin : g_bad_pc
      $error("PC_W must be 8 to 16");
    end
    if (IO_DEPTH < 2 || IO_DEPTH > 32 || (IO_DEPTH & (IO_DEPTH - 1)) != 0)
    begin : g_bad_io
      $error("IO_DEPTH must be a power of two, 2 to 32");
    end
  endgenerate

  // ****************************************
  // state declarations
  // ****************************************
  cbse_pkg::cbse_state_t state_r;      // sequencer state
  cbse_pkg::cbse_cmd_t   cmd_r;        // latched command
  cbse_pkg::cbse_sreg_t  sreg_r;       // status flags
  cbse_pkg::cbse_sreg_t  sh_flags;     // flags from shifter
  logic [PC_W-1:0]       pc_r;         // program counter
  logic [PC_W-1:0]       tgt_r;        // latched branch target
  logic [PC_W-1:0]       br_target;    // computed target
  logic [PC_W-1:0]       pc_inc;       // counter plus one
  logic [7:0]            wreg_r;       // working register
  logic [7:0]            sh_res;       // shifter result
  logic [7:0]            io_mem [IO_DEPTH]; // i/o registers
  logic                  ack_r;        // bus acknowledge
  logic [31:0]           dat_r;        // read data register
  logic [31:0]           rd_nxt;       // read data next
  logic                  taken_r;      // last branch taken
  logic [1:0]            cyc_r;        // cycles of last instruction
  logic                  br_taken;     // condition true
  logic                  req;          // bus request present
  logic                  wr_fire;      // bus write takes effect
  logic                  io_hit;       // address in i/o window
  logic [4:0]            io_word;      // word index in window
  logic [IO_AW-1:0]      io_idx;       // bus i/o index
  logic [IO_AW-1:0]      ex_idx;       // executing i/o index
  logic                  op_ok;        // command code legal
  logic                  start;        // launch instruction
  logic                  idle;         // sequencer idle
  logic                  is_br;        // command is a branch
  logic                  is_io;        // command is i/o bit op
  logic                  is_sh;        // command is a shift
  logic [7:0]            io_cur;       // selected i/o byte
  logic [7:0]            io_mod;       // i/o byte after bit op

  // ****************************************
  // decode helpers
  // ****************************************
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr_fire = req & wb_we_i & ack_r; // write lands on the ack edge
  assign idle    = (state_r == cbse_pkg::ST_IDLE);
  // offset from the window base, one word per i/o register
  assign io_word = 5'((wb_adr_i - cbse_pkg::ADR_IO_BASE) >> cbse_pkg::IO_IDX_LSB);
  assign io_idx  = io_word[IO_AW-1:0];
  assign io_hit  = (wb_adr_i >= cbse_pkg::ADR_IO_BASE)
                 && ({1'b0, wb_adr_i} < 9'(cbse_pkg::ADR_IO_BASE) + 9'(4 * IO_DEPTH));
  assign op_ok   = (wb_dat_i[4:0] <= cbse_pkg::OP_LAST);
  assign start   = wr_fire && idle && op_ok
                 && (wb_adr_i == cbse_pkg::ADR_CMD)
                 && (wb_sel_i == cbse_pkg::SEL_ALL);
  assign is_br   = (cmd_r.op[4] == 1'b0);
  assign is_io   = (cmd_r.op == cbse_pkg::OP_IO_BIT_SET_OP)
                 || (cmd_r.op == cbse_pkg::OP_IO_BIT_CLEAR_OP);
  assign is_sh   = (cmd_r.op == cbse_pkg::OP_SHIFT_LEFT_LOGICAL)
                 || (cmd_r.op == cbse_pkg::OP_SHIFT_RIGHT_LOGICAL);
  assign pc_inc  = pc_r + PC_W'(1);
  assign ex_idx  = cmd_r.port[IO_AW-1:0];
  assign io_cur  = io_mem[ex_idx];

  // ****************************************
  // datapath units
  // ****************************************
  cbse_branch_unit #(
    .PC_W     (PC_W)
  ) u_branch (
    .op_i     (cmd_r.op),
    .flags_i  (sreg_r),
    .pc_i     (pc_r),
    .disp_i   (cmd_r.disp),
    .taken_o  (br_taken),
    .target_o (br_target)
  );

  cbse_shifter u_shift (
    .right_i  (cmd_r.op == cbse_pkg::OP_SHIFT_RIGHT_LOGICAL),
    .val_i    (wreg_r),
    .flags_i  (sreg_r),
    .res_o    (sh_res),
    .flags_o  (sh_flags)
  );

  // bit set or clear on the addressed i/o byte
  always_comb
  begin
    io_mod = io_cur;
    if (cmd_r.op == cbse_pkg::OP_IO_BIT_SET_OP)
    begin
      io_mod[cmd_r.bitsel] = 1'b1; // RL9
    end
    else
    begin
      io_mod[cmd_r.bitsel] = 1'b0; // RL10
    end
  end

  // ****************************************
  // wishbone acknowledge
  // ****************************************
  // one wait state, ack drops the cycle after it was given
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
    end
    else if (ce_i)
    begin
      ack_r <= req & ~ack_r;
    end
  end

  // ****************************************
  // read mux
  // ****************************************
  always_comb
  begin
    rd_nxt = 32'h0000_0000; // unmapped reads as zero
    if (io_hit)
    begin
      rd_nxt[7:0] = io_mem[io_idx];
    end
    else
    begin
      case (wb_adr_i)
        cbse_pkg::ADR_CMD:  rd_nxt = cmd_r;
        cbse_pkg::ADR_PC:   rd_nxt[PC_W-1:0] = pc_r;
        cbse_pkg::ADR_SREG: rd_nxt[7:0] = sreg_r;
        cbse_pkg::ADR_WREG: rd_nxt[7:0] = wreg_r;
        cbse_pkg::ADR_STAT:
        begin
          rd_nxt[cbse_pkg::STAT_BUSY_BIT]     = ~idle;
          rd_nxt[cbse_pkg::STAT_TAKEN_BIT]    = taken_r;
          rd_nxt[cbse_pkg::STAT_CYC_LSB +: 2] = cyc_r;
        end
        default: rd_nxt = 32'h0000_0000; // unmapped
      endcase
    end
  end

  // read data captured as ack rises
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_r <= 32'h0000_0000;
    end
    else if (ce_i && req && !ack_r)
    begin
      dat_r <= rd_nxt;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r <= cbse_pkg::ST_IDLE;
    end
    else if (ce_i)
    begin
      case (state_r)
        cbse_pkg::ST_IDLE:
        begin
          if (start)
          begin
            state_r <= cbse_pkg::ST_EXEC1;
          end
        end
        cbse_pkg::ST_EXEC1:
        begin
          // taken branch and i/o op need a second cycle
          if ((is_br && br_taken) || is_io) // RL8
          begin
            state_r <= cbse_pkg::ST_EXEC2;
          end
          else
          begin
            state_r <= cbse_pkg::ST_IDLE;
          end
        end
        cbse_pkg::ST_EXEC2: state_r <= cbse_pkg::ST_IDLE;
        default:            state_r <= cbse_pkg::ST_IDLE;
      endcase
    end
  end

  // command latch, taken only while idle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_r <= '0;
    end
    else if (ce_i && start)
    begin
      cmd_r <= wb_dat_i;
    end
  end

  // target latched so the second cycle uses first-cycle counter
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tgt_r <= '0;
    end
    else if (ce_i && state_r == cbse_pkg::ST_EXEC1)
    begin
      tgt_r <= br_target; // RL1
    end
  end

  // ****************************************
  // program counter
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pc_r <= '0;
    end
    else if (ce_i)
    begin
      if (state_r == cbse_pkg::ST_EXEC1 && !(is_br && br_taken) && !is_io)
      begin
        pc_r <= pc_inc; // not taken or shift
      end
      else if (state_r == cbse_pkg::ST_EXEC2)
      begin
        pc_r <= is_br ? tgt_r : pc_inc; // RL1
      end
      else if (idle && wr_fire && wb_adr_i == cbse_pkg::ADR_PC)
      begin
        if (wb_sel_i[0])
        begin
          pc_r[7:0] <= wb_dat_i[7:0];
        end
        // bit loop keeps an 8-bit counter legal
        for (int b = 8; b < PC_W; b++)
        begin
          if (wb_sel_i[1])
          begin
            pc_r[b] <= wb_dat_i[b];
          end
        end
      end
    end
  end

  // ****************************************
  // status flags and working register
  // ****************************************
  // only shifts touch the flags; branches and i/o ops leave them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sreg_r <= cbse_pkg::SREG_RST;
    end
    else if (ce_i)
    begin
      if (state_r == cbse_pkg::ST_EXEC1 && is_sh)
      begin
        sreg_r <= sh_flags; // RL11
      end
      else if (idle && wr_fire && wb_adr_i == cbse_pkg::ADR_SREG && wb_sel_i[0])
      begin
        sreg_r <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wreg_r <= cbse_pkg::WREG_RST;
    end
    else if (ce_i)
    begin
      if (state_r == cbse_pkg::ST_EXEC1 && is_sh)
      begin
        wreg_r <= sh_res; // RL12
      end
      else if (idle && wr_fire && wb_adr_i == cbse_pkg::ADR_WREG && wb_sel_i[0])
      begin
        wreg_r <= wb_dat_i[7:0];
      end
    end
  end

  // ****************************************
  // i/o registers
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < IO_DEPTH; i++)
      begin
        io_mem[i] <= cbse_pkg::IO_RST;
      end
    end
    else if (ce_i)
    begin
      if (state_r == cbse_pkg::ST_EXEC2 && is_io)
      begin
        io_mem[ex_idx] <= io_mod; // RL9 RL10
      end
      else if (idle && wr_fire && io_hit && wb_sel_i[0])
      begin
        io_mem[io_idx] <= wb_dat_i[7:0];
      end
    end
  end

  // ****************************************
  // execution status
  // ****************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      taken_r <= 1'b0;
      cyc_r   <= 2'h0;
    end
    else if (ce_i && state_r == cbse_pkg::ST_EXEC1)
    begin
      taken_r <= is_br & br_taken;
      if (is_br)
      begin
        cyc_r <= br_taken ? cbse_pkg::CYC_BR_T : cbse_pkg::CYC_BR_NT; // RL8
      end
      else
      begin
        cyc_r <= is_io ? cbse_pkg::CYC_IO : cbse_pkg::CYC_SH;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign busy_o   = ~idle;
  assign pc_o     = pc_r;
  assign sreg_o   = sreg_r;

endmodule : cbse_exec_top
`default_nettype wire

// ===== cbse_pkg.sv
// cbse_pkg: shared types, register map and encodings of the branch/bit-io/shift executor
package cbse_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] ADR_CMD     = 8'h00; // command word, write starts
  localparam logic [7:0] ADR_PC      = 8'h04; // program counter
  localparam logic [7:0] ADR_SREG    = 8'h08; // status flags
  localparam logic [7:0] ADR_WREG    = 8'h0c; // working register
  localparam logic [7:0] ADR_STAT    = 8'h10; // execution status, read only
  localparam logic [7:0] ADR_IO_BASE = 8'h40; // i/o register window base
  localparam logic [7:0] ADR_IO_MASK = 8'hc0; // i/o window decode mask

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int unsigned STAT_BUSY_BIT  = 0;     // executing
  localparam int unsigned STAT_TAKEN_BIT = 1;     // last branch taken
  localparam int unsigned STAT_CYC_LSB   = 4;     // last cycle count
  localparam int unsigned IO_IDX_LSB     = 2;     // word index in window
  localparam int unsigned DISP_W         = 7;     // displacement width
  localparam logic [7:0]  SREG_RST       = 8'h00; // flags after reset
  localparam logic [7:0]  WREG_RST       = 8'h00; // working reg after reset
  localparam logic [7:0]  IO_RST         = 8'h00; // i/o regs after reset
  localparam logic [3:0]  SEL_ALL        = 4'hf;  // all byte lanes

  // ****************************************
  // cycle counts per instruction class
  // ****************************************
  localparam logic [1:0] CYC_BR_NT = 2'h1; // branch not taken
  localparam logic [1:0] CYC_BR_T  = 2'h2; // branch taken
  localparam logic [1:0] CYC_IO    = 2'h2; // i/o bit set/clear
  localparam logic [1:0] CYC_SH    = 2'h1; // logical shift

  // ****************************************
  // operation codes
  // ****************************************
  typedef enum logic [4:0] {
    OP_BRANCH_ON_CARRY_SET     = 5'h00,
    OP_BRANCH_ON_CARRY_CLEAR   = 5'h01,
    OP_BRANCH_SAME_OR_HIGHER   = 5'h02,
    OP_BRANCH_LOWER_UNSIGNED   = 5'h03,
    OP_BRANCH_ON_NEGATIVE      = 5'h04,
    OP_BRANCH_ON_POSITIVE      = 5'h05,
    OP_BRANCH_SIGNED_GE        = 5'h06,
    OP_BRANCH_SIGNED_LT        = 5'h07,
    OP_BRANCH_HALFCARRY_SET    = 5'h08,
    OP_BRANCH_HALFCARRY_CLEAR  = 5'h09,
    OP_BRANCH_TBIT_SET         = 5'h0a,
    OP_BRANCH_TBIT_CLEAR       = 5'h0b,
    OP_BRANCH_OVERFLOW_SET     = 5'h0c,
    OP_BRANCH_OVERFLOW_CLEAR   = 5'h0d,
    OP_BRANCH_IRQ_ENABLED      = 5'h0e,
    OP_BRANCH_IRQ_DISABLED     = 5'h0f,
    OP_IO_BIT_SET_OP           = 5'h10,
    OP_IO_BIT_CLEAR_OP         = 5'h11,
    OP_SHIFT_LEFT_LOGICAL      = 5'h12,
    OP_SHIFT_RIGHT_LOGICAL     = 5'h13
  } cbse_op_t;

  localparam logic [4:0] OP_LAST = 5'h13; // highest legal code

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic i; // global interrupt enable
    logic t; // transfer bit
    logic h; // half carry
    logic s; // signed test
    logic v; // overflow
    logic n; // negative
    logic z; // zero
    logic c; // carry
  } cbse_sreg_t;

  typedef struct packed {
    logic [2:0] rsv0;   // 31:29
    logic [4:0] port;   // 28:24 i/o address
    logic [4:0] rsv1;   // 23:19
    logic [2:0] bitsel; // 18:16 bit number
    logic       rsv2;   // 15
    logic [6:0] disp;   // 14:8 signed displacement
    logic [2:0] rsv3;   // 7:5
    logic [4:0] op;     // 4:0 operation
  } cbse_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00, // waiting for command
    ST_EXEC1 = 2'b01, // first execution cycle
    ST_EXEC2 = 2'b11  // second execution cycle
  } cbse_state_t;

endpackage : cbse_pkg

// ===== cbse_shifter.sv
// cbse_shifter: one-bit logical shift with flag update
`timescale 1ns/1ps
`default_nettype none
module cbse_shifter (
  input  wire logic                  right_i,  // 1 shift right, 0 left
  input  wire logic [7:0]            val_i,    // operand
  input  wire cbse_pkg::cbse_sreg_t  flags_i,  // flags before
  output logic [7:0]                 res_o,    // shifted result
  output cbse_pkg::cbse_sreg_t       flags_o   // flags after
);

  // ****************************************
  // shift and flags
  // ****************************************
  always_comb
  begin
    flags_o = flags_i; // s, h, t, i pass through
    if (right_i)
    begin
      res_o     = {1'b0, val_i[7:1]}; // RL12
      flags_o.c = val_i[0];           // RL14
    end
    else
    begin
      res_o     = {val_i[6:0], 1'b0}; // RL11
      flags_o.c = val_i[7];           // RL14
    end
    flags_o.z = (res_o == 8'h00);       // RL11
    flags_o.n = res_o[7];               // RL11
    flags_o.v = res_o[7] ^ flags_o.c;   // RL12
  end

endmodule : cbse_shifter
`default_nettype wire

// ===== test_cpu_branch_bitio_shift_exec.sv
// test_cpu_branch_bitio_shift_exec: self-checking bench for the executor
`timescale 1ns/1ps
`default_nettype none
module test_cpu_branch_bitio_shift_exec;
  localparam int unsigned PC_W = 12;    // counter width
  localparam int          MSK = 12'hfff; // counter wrap mask
  localparam logic [7:0]  RA [5] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h20}; // reset reads
  logic            clk_i = 1'b0;  // clock
  logic            rst_i = 1'b1;  // reset
  logic            cyc = 1'b0;    // bus cycle
  logic            stb = 1'b0;    // strobe
  logic            we = 1'b0;     // write
  logic [7:0]      adr = 8'h00;   // address
  logic [31:0]     wdat = 32'h0;  // write data
  logic [31:0]     rdat;          // read data
  logic            ack;           // acknowledge
  logic            busy;          // executing
  logic [PC_W-1:0] pc;            // counter
  logic [7:0]      sreg;          // flags
  int              error_cnt = 0; // mismatches
  int              n_checks = 0;  // comparisons
  int              seed = 45005;  // random seed
  int              tick = 0;      // cycle count
  cbse_exec_top #(.PC_W(PC_W), .IO_DEPTH(32)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(cbse_pkg::SEL_ALL),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .busy_o(busy), .pc_o(pc), .sreg_o(sreg));
  // clock and hang guard
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    tick <= tick + 1;
    if (tick == 30000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // one classic cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
    end while (ack !== 1'b1); // only the bench timeout ends a hang
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  // issue a command and poll until idle
  task automatic run(input int cmd, output logic [31:0] q);
    bus(1'b1, cbse_pkg::ADR_CMD, cmd, q);
    repeat (4)
    begin
      bus(1'b0, cbse_pkg::ADR_STAT, 32'h0, q);
      if (q[0] === 1'b0)
        break;
    end
  endtask : run
  task automatic post(input int ep, input int ef, input int en);
    logic [31:0] q;
    bus(1'b0, cbse_pkg::ADR_PC, 32'h0, q);
    chk("pc", ep, q);
    bus(1'b0, cbse_pkg::ADR_SREG, 32'h0, q);
    chk("sreg", ef, q);
    bus(1'b0, cbse_pkg::ADR_STAT, 32'h0, q);
    chk("cycles", en, q[5:4]);
    chk("pc_o", ep, pc);
    chk("sreg_o", ef, sreg);
    chk("busy_o", 0, busy);
  endtask : post
  // branch condition model: i t h s v n z c
  function automatic bit taken(int op, int f);
    case (op)
      0, 3: return f[0];
      1, 2: return !f[0];
      4: return f[2];
      5: return !f[2];
      6: return !(f[2] ^ f[3]);
      7: return f[2] ^ f[3];
      8: return f[5];
      9: return !f[5];
      10: return f[6];
      11: return !f[6];
      12: return f[3];
      13: return !f[3];
      14: return f[7];
      default: return !f[7];
    endcase
  endfunction : taken
  initial
  begin
    logic [31:0] q;
    int p, f, d, mp, w, r, c, prt, bt;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b1, 8'h20, 32'hffffffff, q);
    foreach (RA[j])
    begin
      bus(1'b0, RA[j], 32'h0, q);
      chk("reset", 32'h0, q);
    end
    // every branch, both outcomes, edge displacements
    for (int op = 0; op < 16; op++)
      for (int k = 0; k < 2; k++)
      begin
        p = $random(seed) & MSK;
        f = k ? f ^ ((op >> 1) == 3 ? 8'h04 : 8'hff) : $random(seed) & 8'hff;
        d = k ? $random(seed) & 8'h7f : (op % 2 ? 63 : 64);
        bus(1'b1, cbse_pkg::ADR_PC, p, q);
        bus(1'b1, cbse_pkg::ADR_SREG, f, q);
        run(op | (d << 8), q);
        chk("taken", taken(op, f), q[1]);
        mp = (taken(op, f) ? p + d - (d > 63 ? 128 : 0) + 1 : p + 1) & MSK;
        post(mp, f, taken(op, f) ? 2 : 1);
      end
    // i/o bit set and clear
    for (int j = 0; j < 8; j++)
    begin
      prt = $random(seed) & 31;
      bt = $random(seed) & 7;
      w = $random(seed) & 255;
      bus(1'b1, cbse_pkg::ADR_IO_BASE + 8'(prt * 4), w, q);
      run(16 + j % 2 | (bt << 16) | (prt << 24), q);
      w = j % 2 ? w & ~(1 << bt) : w | (1 << bt);
      bus(1'b0, cbse_pkg::ADR_IO_BASE + 8'(prt * 4), 32'h0, q);
      chk("io", w, q);
      mp = (mp + 1) & MSK;
      post(mp, f, 2);
    end
    // shifts, first two push a one out to leave zero
    for (int j = 0; j < 8; j++)
    begin
      w = j < 2 ? 8'h80 >> (j * 7) : $random(seed) & 255;
      f = $random(seed) & 255;
      bus(1'b1, cbse_pkg::ADR_WREG, w, q);
      bus(1'b1, cbse_pkg::ADR_SREG, f, q);
      run(18 + j % 2, q);
      r = j % 2 ? w >> 1 : (w << 1) & 255;
      c = j % 2 ? w & 1 : w >> 7;
      f = (f & 8'hf0) | ((r >> 7 ^ c) << 3) | (r >> 5 & 4) | ((r == 0) << 1) | c;
      bus(1'b0, cbse_pkg::ADR_WREG, 32'h0, q);
      chk("wreg", r, q);
      mp = (mp + 1) & MSK;
      post(mp, f, 1);
    end
    run(31, q);
    post(mp, f, 1);
    finish_test();
  end
endmodule : test_cpu_branch_bitio_shift_exec
`default_nettype wire
